// [core/dts_defines.svh]
// Purpose: Shared constants of the tag select front end and its controller.
// Assumes: Included by its bare name from the slave, master, assertion and bench files.
// Notes: Offsets are byte addresses on the register bus.
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH
// Type code value is arbitrary.
`define DTS_TYPE_ID 4'h6
`define DTS_MEM_BYTES 8192
`define DTS_ADDR_W 13
`define DTS_HCLK_HZ 200000000
`define DTS_SCL_HZ 400000
`define DTS_QTR_CYC (`DTS_HCLK_HZ / (`DTS_SCL_HZ * 4))
`define DTS_CTRL_OFS 32'h0000_0000
`define DTS_DATA_OFS 32'h0000_0004
`define DTS_STAT_OFS 32'h0000_0008
`define DTS_CTRL_GO 0
`define DTS_CTRL_RW 1
`define DTS_CTRL_AREA 2
`define DTS_CTRL_CE_LSB 3
`define DTS_CTRL_TYPE_LSB 8
`define DTS_CTRL_MASK 12'hf1e
`define DTS_CTRL_RST {`DTS_TYPE_ID, 8'h00}
`define DTS_DATA_RST 8'h00
`define DTS_STAT_BUSY 0
`define DTS_STAT_NACK 1
`define DTS_STAT_DONE 2
`endif

// [core/dts_pkg.sv]
// Purpose: State types of both ends.
// Assumes: Nothing.
// Notes: One-hot state codes.
package dts_pkg;
    typedef enum logic [6:0]
    {
        DTS_D_IDLE = 7'h01,
        DTS_D_SEL = 7'h02,
        DTS_D_ACK = 7'h04,
        DTS_D_RX = 7'h08,
        DTS_D_TX = 7'h10,
        DTS_D_MACK = 7'h20,
        DTS_D_IGN = 7'h40
    } dts_dev_state_t;
    typedef enum logic [6:0]
    {
        DTS_M_IDLE = 7'h01,
        DTS_M_START = 7'h02,
        DTS_M_TX = 7'h04,
        DTS_M_ARX = 7'h08,
        DTS_M_RX = 7'h10,
        DTS_M_ATX = 7'h20,
        DTS_M_STOP = 7'h40
    } dts_mst_state_t;
endpackage

// [core/dts_if.sv]
// Purpose: Two-wire link between controller and tag front end.
// Assumes: Data line pulled up; low while any enable is high.
// Notes: Clock line is driven push-pull by the controller.
`timescale 1ns/1ps
interface dts_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
    modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
    modport slave (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface

// [core/dts_sync.sv]
// Purpose: Two-stage synchroniser with edge pulses.
// Assumes: Inputs from outside the hclk domain.
// Notes: Edges are taken from the second stage only.
`timescale 1ns/1ps
module dts_sync #(parameter int W = 1)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    logic [W-1:0] prev_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;
    logic [W-1:0] prev_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt = meta_r;
        prev_nxt = q_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= '0;
            q_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign q = q_r;
    assign rise = q_r & ~prev_r;
    assign fall = ~q_r & prev_r;
endmodule

// [core/dts_slave.sv]
// Purpose: Tag-side select decoder and byte engine on the two-wire link.
// Assumes: Strap pins tied; rd_byte valid whenever a read byte starts.
// Notes: hresetn stands for the power-on reset.
// Summary of operation
// - Slave only, strobed by master clock.
// - Master opens every operation with Start.
// - Select byte then acknowledge follow Start.
// - Device acknowledges each written byte.
// - Master acknowledges each byte it reads; the controller here reads one byte and nacks it.
// - Stop after ack on write, nack read.
// - Bits b2,b1 must match the straps.
// - Floating straps count as low.
// - Select byte sent MSB first.
// - Top four bits must match type code.
// - Bit b3 picks the internal area.
// - Master sets area bit zero for user.
// - Reset clears bus logic into standby.
// - Reset reasserted stops responses at once.
// - Stop returns to standby unless writing.
// - Data line driven open-drain only.
// - Memory seen as 8192 bytes.
// - Clock shifts every bit in and out.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "dts_defines.svh"
module dts_slave
(
    input wire logic hclk,
    input wire logic hresetn,
    dts_if.slave link,
    input wire logic chip_enable_low_strap,
    input wire logic chip_enable_high_strap,
    input wire logic write_busy,
    input wire logic [7:0] rd_byte,
    output logic sel_valid,
    output logic sel_rw,
    output logic internal_area_select,
    output logic [`DTS_ADDR_W-1:0] rd_addr,
    output logic [7:0] wr_byte,
    output logic wr_valid,
    output logic standby
);
    import dts_pkg::*;

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    logic [1:0] pin_q;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic [1:0] ce_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    dts_sync #(.W(2)) u_link_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({link.scl, link.sda}),
        .q(pin_q),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    dts_sync #(.W(2)) u_strap_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({chip_enable_high_strap, chip_enable_low_strap}),
        .q(ce_q),
        .rise(),
        .fall()
    );

    assign scl_s = pin_q[1];
    assign sda_s = pin_q[0];
    assign scl_rise = pin_rise[1];
    assign scl_fall = pin_fall[1];
    assign start_det = pin_fall[0] && scl_s;
    assign stop_det = pin_rise[0] && scl_s;

    // ****************************************************************
    // Select decode.
    // ****************************************************************
    function automatic logic sel_match(input logic [7:0] b, input logic [1:0] ce);
        logic type_ok;
        logic ce_ok;
        type_ok = (b[7:4] == `DTS_TYPE_ID);
        ce_ok = (b[2:1] == ce);
        sel_match = type_ok && ce_ok;
    endfunction

    // ****************************************************************
    // Byte engine.
    // ****************************************************************
    dts_dev_state_t fsm_r;
    dts_dev_state_t fsm_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic oe_r;
    logic oe_nxt;
    logic rw_r;
    logic rw_nxt;
    logic area_r;
    logic area_nxt;
    logic nack_r;
    logic nack_nxt;
    logic [`DTS_ADDR_W-1:0] addr_r;
    logic [`DTS_ADDR_W-1:0] addr_nxt;
    logic selv_r;
    logic selv_nxt;
    logic wrv_r;
    logic wrv_nxt;
    logic [7:0] wrb_r;
    logic [7:0] wrb_nxt;

    always_comb
    begin
        fsm_nxt = fsm_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        oe_nxt = oe_r;
        rw_nxt = rw_r;
        area_nxt = area_r;
        nack_nxt = nack_r;
        addr_nxt = addr_r;
        selv_nxt = 1'b0;
        wrv_nxt = 1'b0;
        wrb_nxt = wrb_r;
        if (start_det)
        begin
            fsm_nxt = DTS_D_SEL;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            fsm_nxt = DTS_D_IDLE;
            oe_nxt = 1'b0;
        end
        else
        begin
            unique case (fsm_r)
                DTS_D_IDLE, DTS_D_IGN:
                begin
                end
                DTS_D_SEL, DTS_D_RX:
                begin
                    if (scl_rise && cnt_r != 4'h8)
                    begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == 4'h8)
                    begin
                        if (fsm_r == DTS_D_RX)
                        begin
                            wrv_nxt = 1'b1;
                            wrb_nxt = sh_r;
                            fsm_nxt = DTS_D_ACK;
                            oe_nxt = 1'b1;
                        end
                        else if (sel_match(sh_r, ce_q))
                        begin
                            fsm_nxt = DTS_D_ACK;
                            oe_nxt = 1'b1;
                            rw_nxt = sh_r[0];
                            area_nxt = sh_r[3];
                            selv_nxt = 1'b1;
                        end
                        else
                        begin
                            fsm_nxt = DTS_D_IGN;
                        end
                    end
                end
                DTS_D_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw_r)
                        begin
                            fsm_nxt = DTS_D_TX;
                            sh_nxt = rd_byte;
                            oe_nxt = !rd_byte[7];
                            cnt_nxt = 4'h1;
                        end
                        else
                        begin
                            fsm_nxt = DTS_D_RX;
                            oe_nxt = 1'b0;
                            cnt_nxt = 4'h0;
                        end
                    end
                end
                DTS_D_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_r == 4'h8)
                        begin
                            oe_nxt = 1'b0;
                            fsm_nxt = DTS_D_MACK;
                            addr_nxt = addr_r + 1'b1;
                        end
                        else
                        begin
                            oe_nxt = !sh_r[6];
                            sh_nxt = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                DTS_D_MACK:
                begin
                    if (scl_rise)
                    begin
                        nack_nxt = sda_s;
                    end
                    if (scl_fall)
                    begin
                        if (!nack_r)
                        begin
                            fsm_nxt = DTS_D_TX;
                            sh_nxt = rd_byte;
                            oe_nxt = !rd_byte[7];
                            cnt_nxt = 4'h1;
                        end
                        else
                        begin
                            fsm_nxt = DTS_D_IGN;
                        end
                    end
                end
            endcase
        end
    end

    // Asynchronous reset blocks all responses at once.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fsm_r <= DTS_D_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            oe_r <= 1'b0;
            rw_r <= 1'b0;
            area_r <= 1'b0;
            nack_r <= 1'b0;
            addr_r <= '0;
            selv_r <= 1'b0;
            wrv_r <= 1'b0;
            wrb_r <= 8'h00;
        end
        else
        begin
            fsm_r <= fsm_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            oe_r <= oe_nxt;
            rw_r <= rw_nxt;
            area_r <= area_nxt;
            nack_r <= nack_nxt;
            addr_r <= addr_nxt;
            selv_r <= selv_nxt;
            wrv_r <= wrv_nxt;
            wrb_r <= wrb_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign link.s_sda_o = 1'b0;
    assign link.s_sda_oe = oe_r;
    assign sel_valid = selv_r;
    assign sel_rw = rw_r;
    assign internal_area_select = area_r;
    assign rd_addr = addr_r;
    assign wr_byte = wrb_r;
    assign wr_valid = wrv_r;
    assign standby = (fsm_r == DTS_D_IDLE) && !write_busy;
endmodule

// [core/dts_master.sv]
// Purpose: Two-wire controller with an AHB-Lite register port.
// Assumes: Single word transfers only; one slave on the bus.
// Notes: One select byte, then one data byte unless the select byte is nacked.
`timescale 1ns/1ps
`include "dts_defines.svh"
module dts_master
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    dts_if.master link
);
    import dts_pkg::*;

    localparam logic [7:0] QTR_LAST = 8'(`DTS_QTR_CYC - 1);

    // ****************************************************************
    // Line levels for each state and quarter bit.
    // ****************************************************************
    function automatic logic [1:0] pins(input dts_mst_state_t s, input logic [1:0] q,
                                         input logic b);
        logic hi;
        hi = (q == 2'd1) || (q == 2'd2);
        pins = {hi, 1'b0};
        unique case (s)
            DTS_M_IDLE: pins = 2'b10;
            DTS_M_START: pins = {q != 2'd3, q != 2'd0};
            DTS_M_STOP: pins = {q != 2'd0, q < 2'd2};
            DTS_M_TX: pins = {hi, !b};
            DTS_M_ARX, DTS_M_RX, DTS_M_ATX: pins = {hi, 1'b0};
        endcase
    endfunction

    logic sda_s;

    dts_sync #(.W(1)) u_sda_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(link.sda),
        .q(sda_s),
        .rise(),
        .fall()
    );

    // ****************************************************************
    // Registers and engine.
    // ****************************************************************
    dts_mst_state_t fsm_r, fsm_nxt;
    logic [1:0] q_r, q_nxt;
    logic [7:0] div_r, div_nxt;
    logic [2:0] bcnt_r, bcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic stage_r, stage_nxt;
    logic scl_r, scl_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [11:0] ctrl_r, ctrl_nxt;
    logic [7:0] data_r, data_nxt;
    logic nack_r, nack_nxt;
    logic done_r, done_nxt;
    logic aw_r, aw_nxt;
    logic [31:0] aofs_r, aofs_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic tick;
    logic idle;

    assign idle = (fsm_r == DTS_M_IDLE);
    assign tick = !idle && (div_r == QTR_LAST);

    always_comb
    begin
        fsm_nxt = fsm_r;
        q_nxt = q_r;
        div_nxt = idle ? 8'h00 : (tick ? 8'h00 : div_r + 8'h01);
        bcnt_nxt = bcnt_r;
        sh_nxt = sh_r;
        stage_nxt = stage_r;
        rx_nxt = rx_r;
        ctrl_nxt = ctrl_r;
        data_nxt = data_r;
        nack_nxt = nack_r;
        done_nxt = done_r;
        aw_nxt = 1'b0;
        aofs_nxt = aofs_r;
        hrdata_nxt = hrdata_r;
        if (hsel && hready && htrans[1])
        begin
            aw_nxt = hwrite;
            aofs_nxt = haddr;
            hrdata_nxt = 32'h0000_0000;
            if (!hwrite && haddr == `DTS_CTRL_OFS)
                hrdata_nxt = {20'h00000, ctrl_r};
            if (!hwrite && haddr == `DTS_DATA_OFS)
                hrdata_nxt = {24'h000000, rx_r};
            if (!hwrite && haddr == `DTS_STAT_OFS)
                hrdata_nxt = {29'h00000000, done_r, nack_r, !idle};
        end
        if (aw_r && aofs_r == `DTS_CTRL_OFS && idle)
        begin
            ctrl_nxt = hwdata[11:0] & `DTS_CTRL_MASK;
            if (hwdata[`DTS_CTRL_GO])
            begin
                fsm_nxt = DTS_M_START;
                q_nxt = 2'd0;
                stage_nxt = 1'b0;
            end
        end
        if (aw_r && aofs_r == `DTS_DATA_OFS)
            data_nxt = hwdata[7:0];
        if (aw_r && aofs_r == `DTS_STAT_OFS)
        begin
            nack_nxt = nack_r & !hwdata[`DTS_STAT_NACK];
            done_nxt = done_r & !hwdata[`DTS_STAT_DONE];
        end
        if (tick)
        begin
            q_nxt = q_r + 2'd1;
            if (q_r == 2'd2 && fsm_r == DTS_M_RX)
                sh_nxt = {sh_r[6:0], sda_s};
            if (q_r == 2'd2 && fsm_r == DTS_M_ARX && sda_s)
            begin
                nack_nxt = 1'b1;
                stage_nxt = 1'b1;
            end
            if (q_r == 2'd3)
            begin
                unique case (fsm_r)
                    DTS_M_IDLE:
                    begin
                    end
                    DTS_M_START:
                    begin
                        fsm_nxt = DTS_M_TX;
                        bcnt_nxt = 3'd0;
                        sh_nxt = {ctrl_r[11:8], ctrl_r[2], ctrl_r[4:3], ctrl_r[1]};
                    end
                    DTS_M_TX:
                    begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        bcnt_nxt = bcnt_r + 3'd1;
                        if (bcnt_r == 3'd7)
                            fsm_nxt = DTS_M_ARX;
                    end
                    DTS_M_ARX:
                    begin
                        bcnt_nxt = 3'd0;
                        if (stage_r)
                            fsm_nxt = DTS_M_STOP;
                        else if (ctrl_r[`DTS_CTRL_RW])
                            fsm_nxt = DTS_M_RX;
                        else
                        begin
                            fsm_nxt = DTS_M_TX;
                            sh_nxt = data_r;
                        end
                        stage_nxt = 1'b1;
                    end
                    DTS_M_RX:
                    begin
                        bcnt_nxt = bcnt_r + 3'd1;
                        if (bcnt_r == 3'd7)
                        begin
                            fsm_nxt = DTS_M_ATX;
                            rx_nxt = sh_r;
                        end
                    end
                    DTS_M_ATX: fsm_nxt = DTS_M_STOP;
                    DTS_M_STOP:
                    begin
                        fsm_nxt = DTS_M_IDLE;
                        done_nxt = 1'b1;
                    end
                endcase
            end
        end
        {scl_nxt, oe_nxt} = pins(fsm_nxt, q_nxt, sh_nxt[7]);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fsm_r <= DTS_M_IDLE;
            q_r <= 2'd0;
            div_r <= 8'h00;
            bcnt_r <= 3'd0;
            sh_r <= 8'h00;
            stage_r <= 1'b0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            rx_r <= `DTS_DATA_RST;
            ctrl_r <= `DTS_CTRL_RST;
            data_r <= `DTS_DATA_RST;
            nack_r <= 1'b0;
            done_r <= 1'b0;
            aw_r <= 1'b0;
            aofs_r <= 32'h0000_0000;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            fsm_r <= fsm_nxt;
            q_r <= q_nxt;
            div_r <= div_nxt;
            bcnt_r <= bcnt_nxt;
            sh_r <= sh_nxt;
            stage_r <= stage_nxt;
            scl_r <= scl_nxt;
            oe_r <= oe_nxt;
            rx_r <= rx_nxt;
            ctrl_r <= ctrl_nxt;
            data_r <= data_nxt;
            nack_r <= nack_nxt;
            done_r <= done_nxt;
            aw_r <= aw_nxt;
            aofs_r <= aofs_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign link.scl = scl_r;
    assign link.m_sda_o = 1'b0;
    assign link.m_sda_oe = oe_r;
endmodule

// [verif/dts_assertions.sv]
// Purpose: Link checks beside the two ends.
// Assumes: One controller and one tag on the link.
// Notes: None.
`timescale 1ns/1ps
`include "dts_defines.svh"
module dts_assertions
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic sda
);
    localparam int HI_CYC = 2 * `DTS_QTR_CYC;
    logic scl_r, sda_r, frm_r, frm_nxt, start, stop;
    logic [4:0] cnt_r, cnt_nxt;
    logic [8:0] hi_r, hi_nxt;
    always_comb
    begin
        start = scl && scl_r && sda_r && !sda;
        stop = scl && scl_r && !sda_r && sda;
        frm_nxt = start ? 1'b1 : (stop ? 1'b0 : frm_r);
        cnt_nxt = cnt_r;
        if (scl && !scl_r && cnt_r != 5'h1f)
            cnt_nxt = cnt_r + 5'h01;
        if (start)
            cnt_nxt = 5'h00;
        hi_nxt = !scl ? 9'h000 : (hi_r == 9'h1ff ? hi_r : hi_r + 9'h001);
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            frm_r <= 1'b0;
            cnt_r <= 5'h00;
            hi_r <= 9'h000;
        end
        else
        begin
            scl_r <= scl;
            sda_r <= sda;
            frm_r <= frm_nxt;
            cnt_r <= cnt_nxt;
            hi_r <= hi_nxt;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_od;
        !m_sda_o && !s_sda_o;
    endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_rst;
        $rose(hresetn) |-> scl && !s_sda_oe && !m_sda_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("link busy after reset");
    property p_chg;
        $changed(s_sda_oe) |-> !scl;
    endproperty
    a_chg: assert property (p_chg) else $error("tag changed data with clock high");
    property p_frame;
        s_sda_oe |-> frm_r;
    endproperty
    a_frame: assert property (p_frame) else $error("tag drove outside a frame");
    property p_ack9;
        $rose(s_sda_oe) && cnt_r < 5'h09 |-> cnt_r == 5'h08;
    endproperty
    a_ack9: assert property (p_ack9) else $error("select ack not in ninth bit");
    property p_idle;
        !frm_r |-> scl;
    endproperty
    a_idle: assert property (p_idle) else $error("clock low outside a frame");
    property p_hi;
        $fell(scl) && cnt_r != 5'h00 |-> hi_r == HI_CYC;
    endproperty
    a_hi: assert property (p_hi) else $error("clock high phase wrong");
    property p_stop;
        stop |-> !s_sda_oe && $past(s_sda_oe, 2) == 1'b0;
    endproperty
    a_stop: assert property (p_stop) else $error("tag held data at stop");
endmodule

// [verif/tb.sv]
// Purpose: Bench driving the controller registers over the bus.
// Assumes: Straps driven as levels.
// Notes: None.
`timescale 1ns/1ps
`include "dts_defines.svh"
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0] htrans, strap [4];
    logic [2:0] hsize;
    logic ce_lo, ce_hi, write_busy, sel_valid, sel_rw, area, wr_valid, standby;
    logic [7:0] rd_byte, wr_byte;
    logic [12:0] rd_addr;
    logic [31:0] ctl [4], ex [4];
    int n_fail, compares, n;
    int n_sel = 0;
    int n_wr = 0;
    dts_if link();
    assign hready = hreadyout;
    dts_master u_dts_master(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.master));
    dts_slave u_dts_slave(.hclk(hclk), .hresetn(hresetn), .link(link.slave),
        .chip_enable_low_strap(ce_lo), .chip_enable_high_strap(ce_hi),
        .write_busy(write_busy), .rd_byte(rd_byte), .sel_valid(sel_valid), .sel_rw(sel_rw),
        .internal_area_select(area), .rd_addr(rd_addr), .wr_byte(wr_byte),
        .wr_valid(wr_valid), .standby(standby));
    dts_assertions u_dts_assertions(.hclk(hclk), .hresetn(hresetn), .scl(link.scl),
        .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o),
        .s_sda_oe(link.s_sda_oe), .sda(link.sda));
    always @(posedge hclk)
    begin
        if (sel_valid === 1'b1)
            n_sel <= n_sel + 1;
        if (wr_valid === 1'b1)
            n_wr <= n_wr + 1;
    end
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic conclude;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic hwait;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hwait();
        htrans <= 2'h0;
        hwdata <= d;
        hwait();
        rd_q = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask
    task automatic op(input logic [31:0] c, input logic [31:0] exp);
        int k;
        xfer(1'b1, `DTS_CTRL_OFS, c);
        k = 0;
        do
        begin
            xfer(1'b0, `DTS_STAT_OFS, 32'h0);
            k++;
        end
        while (rd_q[`DTS_STAT_DONE] !== 1'b1 && k < 20000);
        chk(rd_q, exp);
        if (k >= 20000)
            conclude();
        xfer(1'b1, `DTS_STAT_OFS, 32'h6);
    endtask
    initial
    begin
        n_fail = 0;
        compares = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ce_lo = 1'b0;
        ce_hi = 1'b1;
        write_busy = 1'b0;
        rd_byte = 8'hc5;
        ctl = '{32'h511, 32'h609, 32'h601, 32'h601};
        ex = '{32'h6, 32'h6, 32'h6, 32'h4};
        strap = '{2'h2, 2'h2, 2'h2, 2'h0};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({30'h0, hresp, standby}, 32'h1);
        rd(`DTS_CTRL_OFS, {20'h0, `DTS_CTRL_RST});
        rd(`DTS_STAT_OFS, 32'h0);
        xfer(1'b1, 32'h10, 32'hffff_ffff);
        rd(32'h10, 32'h0);
        xfer(1'b1, `DTS_DATA_OFS, 32'ha5);
        op(32'h611, 32'h4);
        chk({24'h0, wr_byte}, 32'ha5);
        chk(n_sel, 32'h1);
        chk(n_wr, 32'h1);
        chk({31'h0, sel_rw}, 32'h0);
        chk({31'h0, area}, 32'h0);
        chk({31'h0, standby}, 32'h1);
        op(32'h617, 32'h4);
        rd(`DTS_DATA_OFS, 32'hc5);
        chk({31'h0, sel_rw}, 32'h1);
        chk({31'h0, area}, 32'h1);
        chk({19'h0, rd_addr}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            {ce_hi, ce_lo} <= strap[i];
            op(ctl[i], ex[i]);
        end
        chk(n_sel, 32'h3);
        chk(n_wr, 32'h2);
        write_busy <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({31'h0, standby}, 32'h0);
        write_busy <= 1'b0;
        xfer(1'b1, `DTS_CTRL_OFS, 32'h601);
        n = 0;
        while (link.s_sda_oe !== 1'b1 && n < 20000)
        begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, link.s_sda_oe}, 32'h1);
        if (n >= 20000)
            conclude();
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({31'h0, link.s_sda_oe}, 32'h0);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`DTS_STAT_OFS, 32'h0);
        chk({19'h0, rd_addr}, 32'h0);
        chk(n_sel, 32'h4);
        conclude();
    end
endmodule
